// ==== logic/apc_ctrl_regs.sv ====
// Two-wire control port slave and the first four amplifier registers.
`timescale 1ns/1ps
// Function
// [RULE1] Identity register at zero is read-only.
// [RULE2] Power bits 7:2 give threshold's upper bits.
// [RULE3] Sleep disables power stage, standby stays.
// [RULE4] Cleared run bit shuts both domains.
// [RULE5] Bit 7 set skips the high-pass filter.
// [RULE6] Host leaves reserved digital bit six zero.
// [RULE7] Boost field adds 0/6/12/18 dB.
// [RULE8] Speed bit picks single or double rates.
// [RULE9] Format field selects justified or I2S input.
// [RULE10] Host never writes format codes above five.
// [RULE11] Volume register: fade, reserved, two mutes.
// [RULE12] Channel mute drives outputs to half duty.
// [RULE13] Fade bit enables fading, resets to one.
// [RULE14] Reset restores defaults before any access.
// [RULE15] Writes touch only the writable bits.
module apc_ctrl_regs
   import apc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [13:0] clip_threshold_low_i,
   output logic [19:0] clip_threshold_level_o,
   output logic power_stage_enable_o,
   output logic low_voltage_standby_o,
   output logic digital_supply_domain_en_o,
   output logic power_stage_supply_domain_en_o,
   output logic highpass_skip_o,
   output logic [4:0] boost_db_o,
   output logic rate_speed_select_o,
   output logic [2:0] input_format_o,
   output logic fade_enable_o,
   output logic mute_left_o,
   output logic mute_right_o
);

   // ==========================================================================
   // Register storage.
   // ==========================================================================
   logic [7:0] power_state_ctrl_r; // Clip upper bits, sleep and run.
   logic [7:0] digital_path_ctrl_r; // Path controls; bit 6 held at zero.
   logic [7:0] volume_config_r; // Fade and mutes; bits 6:2 held at zero.

   // Read value of a register, with unmapped offsets reading zero.
   function automatic logic [7:0] rd_data(input logic [7:0] adr, input logic [7:0] pwr, input logic [7:0] dig,
                                          input logic [7:0] vol);
      case (adr)
         ADR_CHIP_IDENTITY: rd_data = RST_CHIP_IDENTITY; // [RULE1]
         ADR_POWER_STATE_CTRL: rd_data = pwr;
         ADR_DIGITAL_PATH_CTRL: rd_data = dig;
         ADR_VOLUME_CONFIG: rd_data = vol;
         default: rd_data = 8'h00;
      endcase
   endfunction : rd_data

   // Merges a written byte through the writable-bit mask.
   function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] mask);
      merge = (cur & ~mask) | (wd & mask);
   endfunction : merge

   // ==========================================================================
   // Pin synchronisers and bus condition detection.
   // ==========================================================================
   logic scl_lvl; // Filtered clock line.
   logic sda_lvl; // Filtered data line.
   logic scl_d_r; // Previous filtered clock line.
   logic sda_d_r; // Previous filtered data line.
   logic scl_rise; // Clock line rose.
   logic scl_fall; // Clock line fell.
   logic bus_start; // Data fell while clock high.
   logic bus_stop; // Data rose while clock high.

   apc_pin_sync #(
      .RESET_LEVEL(1'b1)
   ) u_scl_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .pin_i(scl_i),
      .level_o(scl_lvl)
   );

   apc_pin_sync #(
      .RESET_LEVEL(1'b1)
   ) u_sda_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .pin_i(sda_i),
      .level_o(sda_lvl)
   );

   // Previous filtered levels, for edge detection.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_lvl;
         sda_d_r <= sda_lvl;
      end
   end

   assign scl_rise = scl_lvl & ~scl_d_r;
   assign scl_fall = ~scl_lvl & scl_d_r;
   assign bus_start = scl_lvl & scl_d_r & sda_d_r & ~sda_lvl;
   assign bus_stop = scl_lvl & scl_d_r & ~sda_d_r & sda_lvl;

   // ==========================================================================
   // Byte engine.
   // ==========================================================================
   apc_state_e state_r; // Engine state.
   apc_state_e after_ack_r; // State after the acknowledge slot.
   logic [2:0] bit_cnt_r; // Bits seen in the current byte.
   logic [7:0] shift_r; // Bits in and out.
   logic [7:0] reg_ptr_r; // Register pointer, auto-incremented.
   logic ack_pend_r; // Acknowledge is due at the next clock fall.
   logic load_r; // Fetch the next read byte at the next fall.
   logic wr_stb; // A data byte completes in this cycle.
   logic [7:0] wr_byte; // Received byte with the current bit.
   logic [7:0] rd_byte; // Read value at the pointer.

   assign wr_byte = {shift_r[6:0], sda_lvl};
   assign wr_stb = scl_rise & (state_r == ST_WR) & (bit_cnt_r == 3'h7);
   assign rd_byte = rd_data(reg_ptr_r, power_state_ctrl_r, digital_path_ctrl_r, volume_config_r);

   // Start and stop conditions take priority; bits move on clock edges.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state_r <= ST_IDLE; // [RULE14]
         after_ack_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r <= 8'h00;
         reg_ptr_r <= 8'h00;
         ack_pend_r <= 1'b0;
         load_r <= 1'b0;
      end else if (bus_start) begin
         state_r <= ST_DEV;
         bit_cnt_r <= 3'h0;
         ack_pend_r <= 1'b0;
      end else if (bus_stop) begin
         state_r <= ST_IDLE;
         ack_pend_r <= 1'b0;
      end else if (scl_rise) begin
         case (state_r)
            // Address, pointer and data bytes are shifted in MSB first.
            ST_DEV, ST_REG, ST_WR: begin
               shift_r <= wr_byte;
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (bit_cnt_r == 3'h7) begin
                  ack_pend_r <= 1'b1;
                  if (state_r == ST_DEV) begin
                     if (wr_byte[7:1] != DEV_ADDR) begin
                        state_r <= ST_IDLE;
                        ack_pend_r <= 1'b0;
                     end
                     after_ack_r <= wr_byte[0] ? ST_RD : ST_REG;
                  end else if (state_r == ST_REG) begin
                     reg_ptr_r <= wr_byte;
                     after_ack_r <= ST_WR;
                  end else begin
                     reg_ptr_r <= reg_ptr_r + 8'h01;
                     after_ack_r <= ST_WR;
                  end
               end
            end
            // Read bits are counted as the master samples them.
            ST_RD: begin
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (bit_cnt_r == 3'h7) begin
                  state_r <= ST_MACK;
               end
            end
            // A master acknowledge asks for the next byte; a refusal ends the read.
            ST_MACK: begin
               if (!sda_lvl) begin
                  state_r <= ST_RD;
                  reg_ptr_r <= reg_ptr_r + 8'h01;
                  load_r <= 1'b1;
               end else begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               bit_cnt_r <= bit_cnt_r;
            end
         endcase
      end else if (scl_fall) begin
         if (ack_pend_r) begin
            // The acknowledge slot opens.
            state_r <= ST_ACK;
            ack_pend_r <= 1'b0;
         end else if (state_r == ST_ACK) begin
            // The acknowledge slot closes; a read drives its first bit now.
            state_r <= after_ack_r;
            bit_cnt_r <= 3'h0;
            if (after_ack_r == ST_RD) begin
               shift_r <= {rd_byte[6:0], 1'b0};
            end
         end else if (state_r == ST_RD) begin
            shift_r <= load_r ? {rd_byte[6:0], 1'b0} : {shift_r[6:0], 1'b0};
            load_r <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Open-drain data line.
   // ==========================================================================
   // The line is only ever pulled low; the enable carries the bit.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (bus_start || bus_stop) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (scl_fall) begin
         sda_o <= 1'b0;
         if (ack_pend_r) begin
            sda_oe_o <= 1'b1;
         end else if (state_r == ST_ACK) begin
            sda_oe_o <= (after_ack_r == ST_RD) ? ~rd_byte[7] : 1'b0;
         end else if (state_r == ST_RD) begin
            sda_oe_o <= load_r ? ~rd_byte[7] : ~shift_r[7];
         end else begin
            sda_oe_o <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Register writes.
   // ==========================================================================
   // Each register takes only its writable bits.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         power_state_ctrl_r <= RST_POWER_STATE_CTRL; // [RULE14]
         digital_path_ctrl_r <= RST_DIGITAL_PATH_CTRL; // [RULE14]
         volume_config_r <= RST_VOLUME_CONFIG; // [RULE14]
      end else if (wr_stb) begin
         case (reg_ptr_r)
            ADR_POWER_STATE_CTRL: begin
               power_state_ctrl_r <= merge(power_state_ctrl_r, wr_byte, WMASK_POWER_STATE_CTRL); // [RULE2]
            end
            ADR_DIGITAL_PATH_CTRL: begin
               digital_path_ctrl_r <= merge(digital_path_ctrl_r, wr_byte, WMASK_DIGITAL_PATH_CTRL); // [RULE15]
            end
            ADR_VOLUME_CONFIG: begin
               volume_config_r <= merge(volume_config_r, wr_byte, WMASK_VOLUME_CONFIG); // [RULE11] [RULE15]
            end
            default: begin
               power_state_ctrl_r <= power_state_ctrl_r; // [RULE1]
            end
         endcase
      end
   end

   // ==========================================================================
   // Registered control outputs.
   // ==========================================================================
   apc_path_cfg u_path_cfg (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .power_state_ctrl_i(power_state_ctrl_r),
      .digital_path_ctrl_i(digital_path_ctrl_r),
      .volume_config_i(volume_config_r),
      .clip_threshold_low_i(clip_threshold_low_i),
      .clip_threshold_level_o(clip_threshold_level_o),
      .power_stage_enable_o(power_stage_enable_o),
      .low_voltage_standby_o(low_voltage_standby_o),
      .digital_supply_domain_en_o(digital_supply_domain_en_o),
      .power_stage_supply_domain_en_o(power_stage_supply_domain_en_o),
      .highpass_skip_o(highpass_skip_o),
      .boost_db_o(boost_db_o),
      .rate_speed_select_o(rate_speed_select_o),
      .input_format_o(input_format_o),
      .fade_enable_o(fade_enable_o),
      .mute_left_o(mute_left_o),
      .mute_right_o(mute_right_o)
   );

endmodule : apc_ctrl_regs

// ==== logic/apc_path_cfg.sv ====
// Registered decode of the registers into control levels.
`timescale 1ns/1ps
module apc_path_cfg
   import apc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] power_state_ctrl_i,
   input wire logic [7:0] digital_path_ctrl_i,
   input wire logic [7:0] volume_config_i,
   input wire logic [13:0] clip_threshold_low_i,
   output logic [19:0] clip_threshold_level_o,
   output logic power_stage_enable_o,
   output logic low_voltage_standby_o,
   output logic digital_supply_domain_en_o,
   output logic power_stage_supply_domain_en_o,
   output logic highpass_skip_o,
   output logic [4:0] boost_db_o,
   output logic rate_speed_select_o,
   output logic [2:0] input_format_o,
   output logic fade_enable_o,
   output logic mute_left_o,
   output logic mute_right_o
);

   // Extra gain in dB for a boost code: six dB per step.
   function automatic logic [4:0] boost_db(input logic [1:0] code);
      boost_db = 5'(BOOST_STEP_DB * code);
   endfunction : boost_db

   // ==========================================================================
   // Power and supply domain control.
   // ==========================================================================
   logic run_on; // Amplifier is not shut down.
   logic sleep_on; // Power stage is asleep.
   assign run_on = power_state_ctrl_i[AMP_RUN_BIT];
   assign sleep_on = power_state_ctrl_i[POWER_SLEEP_BIT];

   // Shutdown drops both domains; sleep drops only the power stage.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         power_stage_enable_o <= RST_POWER_STATE_CTRL[AMP_RUN_BIT] & ~RST_POWER_STATE_CTRL[POWER_SLEEP_BIT];
         low_voltage_standby_o <= 1'b0;
         digital_supply_domain_en_o <= RST_POWER_STATE_CTRL[AMP_RUN_BIT];
         power_stage_supply_domain_en_o <= RST_POWER_STATE_CTRL[AMP_RUN_BIT];
      end else begin
         power_stage_enable_o <= run_on & ~sleep_on; // [RULE3] [RULE4]
         low_voltage_standby_o <= run_on & sleep_on; // [RULE3]
         digital_supply_domain_en_o <= run_on; // [RULE4]
         power_stage_supply_domain_en_o <= run_on; // [RULE4]
      end
   end

   // ==========================================================================
   // Digital path and volume controls.
   // ==========================================================================
   // Path settings follow the registers one edge later.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         clip_threshold_level_o <= {RST_POWER_STATE_CTRL[CLIP_HI_MSB:CLIP_HI_LSB], clip_threshold_low_i};
         highpass_skip_o <= RST_DIGITAL_PATH_CTRL[HIGHPASS_SKIP_BIT];
         boost_db_o <= boost_db(RST_DIGITAL_PATH_CTRL[BOOST_MSB:BOOST_LSB]);
         rate_speed_select_o <= RST_DIGITAL_PATH_CTRL[RATE_SPEED_BIT];
         input_format_o <= RST_DIGITAL_PATH_CTRL[FORMAT_MSB:0];
         fade_enable_o <= RST_VOLUME_CONFIG[FADE_BIT];
         mute_left_o <= RST_VOLUME_CONFIG[MUTE_LEFT_BIT];
         mute_right_o <= RST_VOLUME_CONFIG[MUTE_RIGHT_BIT];
      end else begin
         clip_threshold_level_o <= {power_state_ctrl_i[CLIP_HI_MSB:CLIP_HI_LSB], clip_threshold_low_i}; // [RULE2]
         highpass_skip_o <= digital_path_ctrl_i[HIGHPASS_SKIP_BIT]; // [RULE5]
         boost_db_o <= boost_db(digital_path_ctrl_i[BOOST_MSB:BOOST_LSB]); // [RULE7]
         rate_speed_select_o <= digital_path_ctrl_i[RATE_SPEED_BIT]; // [RULE8]
         input_format_o <= digital_path_ctrl_i[FORMAT_MSB:0]; // [RULE9]
         fade_enable_o <= volume_config_i[FADE_BIT]; // [RULE13]
         mute_left_o <= volume_config_i[MUTE_LEFT_BIT]; // [RULE12]
         mute_right_o <= volume_config_i[MUTE_RIGHT_BIT]; // [RULE12]
      end
   end

endmodule : apc_path_cfg

// ==== logic/apc_pin_sync.sv ====
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module apc_pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   output logic level_o
);

   // ==========================================================================
   // Synchroniser chain.
   // ==========================================================================
   logic meta_r; // First stage, read only by the second stage.
   logic s2_r; // Second stage.
   logic s3_r; // Third stage.

   // The chain shifts the pin in on every edge.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         meta_r <= RESET_LEVEL;
         s2_r <= RESET_LEVEL;
         s3_r <= RESET_LEVEL;
      end else begin
         meta_r <= pin_i;
         s2_r <= meta_r;
         s3_r <= s2_r;
      end
   end

   // The level moves only when stages two and three agree.
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         level_o <= RESET_LEVEL;
      end else if (s2_r == s3_r) begin
         level_o <= s3_r;
      end
   end

endmodule : apc_pin_sync

// ==== logic/apc_pkg.sv ====
// Register map, reset values, fields and port states of the amplifier control bank.
package apc_pkg;

   // ==========================================================================
   // Register offsets on the two-wire control port.
   // ==========================================================================
   localparam logic [7:0] ADR_CHIP_IDENTITY = 8'h00;
   localparam logic [7:0] ADR_POWER_STATE_CTRL = 8'h01;
   localparam logic [7:0] ADR_DIGITAL_PATH_CTRL = 8'h02;
   localparam logic [7:0] ADR_VOLUME_CONFIG = 8'h03;

   // ==========================================================================
   // Reset values and writable-bit masks.
   // ==========================================================================
   localparam logic [7:0] RST_CHIP_IDENTITY = 8'h00;
   localparam logic [7:0] RST_POWER_STATE_CTRL = 8'hfd;
   localparam logic [7:0] RST_DIGITAL_PATH_CTRL = 8'h14;
   localparam logic [7:0] RST_VOLUME_CONFIG = 8'h80;
   localparam logic [7:0] WMASK_POWER_STATE_CTRL = 8'hff;
   localparam logic [7:0] WMASK_DIGITAL_PATH_CTRL = 8'hbf;
   localparam logic [7:0] WMASK_VOLUME_CONFIG = 8'h83;

   // ==========================================================================
   // Field positions.
   // ==========================================================================
   localparam int CLIP_HI_MSB = 7;
   localparam int CLIP_HI_LSB = 2;
   localparam int POWER_SLEEP_BIT = 1;
   localparam int AMP_RUN_BIT = 0;
   localparam int HIGHPASS_SKIP_BIT = 7;
   localparam int BOOST_MSB = 5;
   localparam int BOOST_LSB = 4;
   localparam int RATE_SPEED_BIT = 3;
   localparam int FORMAT_MSB = 2;
   localparam int FADE_BIT = 7;
   localparam int MUTE_RIGHT_BIT = 1;
   localparam int MUTE_LEFT_BIT = 0;

   // ==========================================================================
   // Serial input format codes and boost step.
   // ==========================================================================
   localparam logic [2:0] FMT_RJ24 = 3'h0;
   localparam logic [2:0] FMT_RJ20 = 3'h1;
   localparam logic [2:0] FMT_RJ18 = 3'h2;
   localparam logic [2:0] FMT_RJ16 = 3'h3;
   localparam logic [2:0] FMT_I2S = 3'h4;
   localparam logic [2:0] FMT_LJ = 3'h5;
   localparam logic [4:0] BOOST_STEP_DB = 5'h06;

   // ==========================================================================
   // Control-port byte engine states.
   // ==========================================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_REG = 3'b010,
      ST_WR = 3'b011,
      ST_RD = 3'b100,
      ST_ACK = 3'b101,
      ST_MACK = 3'b110
   } apc_state_e;

endpackage : apc_pkg

// ==== tb/apc_ctrl_regs_properties.sv ====
// Concurrent checks on the ports of the control bank.
`timescale 1ns/1ps
module apc_ctrl_regs_properties (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic sda_oe_o,
   input wire logic [13:0] clip_threshold_low_i,
   input wire logic [19:0] clip_threshold_level_o,
   input wire logic power_stage_enable_o,
   input wire logic low_voltage_standby_o,
   input wire logic digital_supply_domain_en_o,
   input wire logic power_stage_supply_domain_en_o,
   input wire logic highpass_skip_o,
   input wire logic [4:0] boost_db_o,
   input wire logic rate_speed_select_o,
   input wire logic [2:0] input_format_o,
   input wire logic fade_enable_o,
   input wire logic mute_left_o,
   input wire logic mute_right_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_domains_move_together: assert property (digital_supply_domain_en_o == power_stage_supply_domain_en_o)
      else $error("Supply domain enables disagree.");
   a_stage_excludes_standby: assert property (!(power_stage_enable_o && low_voltage_standby_o))
      else $error("Power stage and standby both on.");
   a_stage_needs_run: assert property ((power_stage_enable_o || low_voltage_standby_o) |-> digital_supply_domain_en_o)
      else $error("Stage active while shut down.");
   a_run_picks_one: assert property (digital_supply_domain_en_o |-> (power_stage_enable_o != low_voltage_standby_o))
      else $error("Run without one stage state.");
   a_boost_step_values: assert property (boost_db_o inside {5'd0, 5'd6, 5'd12, 5'd18})
      else $error("Boost is not a 6 dB step.");
   a_clip_low_passes: assert property (clip_threshold_level_o[13:0] == $past(clip_threshold_low_i))
      else $error("Low threshold bits lost.");
   a_reset_gives_defaults: assert property ($rose(rstn_i) |-> boost_db_o == 5'd6 && input_format_o == 3'h4 &&
      fade_enable_o && !mute_left_o && !mute_right_o && !highpass_skip_o && !rate_speed_select_o &&
      power_stage_enable_o && !sda_oe_o && clip_threshold_level_o[19:14] == 6'h3f)
      else $error("Reset defaults wrong.");
   a_cfg_moves_quietly: assert property (($changed(input_format_o) || $changed(fade_enable_o)) |-> !$past(sda_oe_o))
      else $error("Setting moved during acknowledge.");
endmodule : apc_ctrl_regs_properties
bind apc_ctrl_regs apc_ctrl_regs_properties apc_ctrl_regs_properties_inst (.ref_clk_i, .rstn_i, .sda_oe_o,
   .clip_threshold_low_i, .clip_threshold_level_o, .power_stage_enable_o, .low_voltage_standby_o,
   .digital_supply_domain_en_o, .power_stage_supply_domain_en_o, .highpass_skip_o, .boost_db_o,
   .rate_speed_select_o, .input_format_o, .fade_enable_o, .mute_left_o, .mute_right_o);

// ==== tb/apc_i2c_host.sv ====
// Host master model that drives the two-wire control port of the bank.
`timescale 1ns/1ps
module apc_i2c_host #(
   parameter logic [6:0] DEV_ADDR = 7'h2a
) (
   input wire logic ref_clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   // =====================
   // Open-drain data wire.
   // =====================
   logic pull_r = 1'b0; // Host pulls the data line low while set.
   // Pulled up: high unless a party pulls it low.
   assign sda_o = ~(pull_r | sda_oe_i);
   initial scl_o = 1'b1;
   // Waits n edges, then steps just past the last one.
   task automatic ph(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : ph
   // Data moves three cycles after the clock falls, never as a start or stop.
   task automatic bit_io(input logic b, output logic r);
      ph(3);
      pull_r = ~b;
      ph(7);
      scl_o = 1'b1;
      ph(10);
      r = sda_o;
      scl_o = 1'b0;
   endtask : bit_io
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      ph(3);
      pull_r = 1'b0;
      ph(7);
      scl_o = 1'b1;
      ph(10);
      pull_r = 1'b1;
      ph(10);
      scl_o = 1'b0;
   endtask : start
   // Stop: data rises while the clock is high.
   task automatic stop();
      ph(3);
      pull_r = 1'b1;
      ph(7);
      scl_o = 1'b1;
      ph(10);
      pull_r = 1'b0;
      ph(10);
   endtask : stop
   // Sends a byte MSB first and samples the ninth bit.
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : byte_io
   // Single-byte write to a register pointer.
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start();
      byte_io({dev, 1'b0}, q, k0);
      byte_io(a, q, k1);
      byte_io(d, q, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask : write_reg
   // Pointer write, repeated start, one byte read, then not-acknowledge.
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start();
      byte_io({DEV_ADDR, 1'b0}, q, k0);
      byte_io(a, q, k1);
      start();
      byte_io({DEV_ADDR, 1'b1}, q, k2);
      byte_io(8'hff, d, k3);
      stop();
      ok = k0 & k1 & k2;
   endtask : read_reg
endmodule : apc_i2c_host

// ==== tb/testbench.sv ====
// Self-checking bench for the amplifier control bank.
`timescale 1ns/1ps
module testbench;
   import apc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [13:0] low_r = 14'h0000; // Lower threshold bits fed from outside.
   logic scl_w, sda_w, sda_o, sda_oe_o, pse, lvs, dig, pwr, hps, spd, fade, ml, mr;
   logic [19:0] clip;
   logic [4:0] boost;
   logic [2:0] fmt;
   logic [7:0] rst_v [4] = '{8'h00, 8'hfd, 8'h14, 8'h80}; // Reset values of the four registers.
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   apc_ctrl_regs #(.DEV_ADDR(7'h2a)) apc_ctrl_regs_inst (.ref_clk_i, .rstn_i, .scl_i(scl_w), .sda_i(sda_w),
      .sda_o, .sda_oe_o, .clip_threshold_low_i(low_r), .clip_threshold_level_o(clip), .power_stage_enable_o(pse),
      .low_voltage_standby_o(lvs), .digital_supply_domain_en_o(dig), .power_stage_supply_domain_en_o(pwr),
      .highpass_skip_o(hps), .boost_db_o(boost), .rate_speed_select_o(spd), .input_format_o(fmt),
      .fade_enable_o(fade), .mute_left_o(ml), .mute_right_o(mr));
   apc_i2c_host #(.DEV_ADDR(7'h2a)) apc_i2c_host_inst (.ref_clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_w), .sda_o(sda_w));
   // 200 MHz clock and a cycle-count ceiling against hangs.
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // Expected digital-path outputs: skip, boost in dB, speed, format.
   function automatic logic [11:0] dig_exp(input logic [7:0] v);
      return {v[7], 5'(v[5:4]) * 5'd6, v[3], v[2:0]};
   endfunction : dig_exp
   // Expected power outputs: threshold, stage, standby and both domains.
   function automatic logic [23:0] pwr_exp(input logic [7:0] v, input logic [13:0] lo);
      return {v[7:2], lo, v[0] & ~v[1], v[0] & v[1], v[0], v[0]};
   endfunction : pwr_exp
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Write; only the own device address is acknowledged.
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      apc_i2c_host_inst.write_reg(dev, a, d, ok);
      check(ok, dev == 7'h2a);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      logic ok;
      apc_i2c_host_inst.read_reg(a, q, ok);
      check({ok, q}, {1'b1, exp});
   endtask : rd
   task automatic tally_and_finish();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      logic [7:0] v;
      void'($urandom(32'h2b02));
      repeat (5) @(posedge ref_clk_i);
      #1 rstn_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      check({boost, fmt, fade, ml, mr, pse, lvs, hps, spd, sda_o}, {5'd6, FMT_I2S, 8'b10010000});
      for (int i = 0; i < 4; i++) begin
         rd(8'(i), rst_v[i]);
      end
      wr(7'h2a, ADR_CHIP_IDENTITY, 8'($urandom) | 8'h01);
      rd(ADR_CHIP_IDENTITY, 8'h00);
      // Every boost step and every legal format; reserved bit kept zero.
      for (int i = 0; i < 8; i++) begin
         v = {1'($urandom), 1'b0, 2'(i % 4), 1'($urandom), 3'(i % 6)};
         wr(7'h2a, ADR_DIGITAL_PATH_CTRL, v);
         check({hps, boost, spd, fmt}, dig_exp(v));
         rd(ADR_DIGITAL_PATH_CTRL, v);
      end
      // All sleep and run pairs, random threshold bits.
      for (int i = 0; i < 4; i++) begin
         v = {6'($urandom), 2'(i)};
         low_r = 14'($urandom);
         wr(7'h2a, ADR_POWER_STATE_CTRL, v);
         check({clip, pse, lvs, dig, pwr}, pwr_exp(v, low_r));
      end
      wr(7'h2a, ADR_VOLUME_CONFIG, 8'hff);
      rd(ADR_VOLUME_CONFIG, 8'h83);
      check({fade, mr, ml}, 3'b111);
      wr(7'h2a, ADR_VOLUME_CONFIG, 8'h02);
      check({fade, mr, ml}, 3'b010);
      // A foreign address is refused and changes nothing.
      wr(7'h2b, ADR_VOLUME_CONFIG, 8'h01);
      rd(ADR_VOLUME_CONFIG, 8'h02);
      rd(8'h09, 8'h00);
      tally_and_finish();
   end
endmodule : testbench
